/* cms_consts.svh */
// Constants for the channel maintenance and status block
`ifndef CMS_CONSTS_SVH
`define CMS_CONSTS_SVH
// Register byte offsets
`define CMS_OFF_CTRL_A 12'h000
`define CMS_OFF_CTRL_B 12'h004
`define CMS_OFF_CARD 12'h008
`define CMS_OFF_STAT 12'h00c
`define CMS_OFF_GAIN_A 12'h010
`define CMS_OFF_GAIN_B 12'h014
// Channel control fields
`define CMS_CTL_LOOP 0
`define CMS_CTL_DEFER 1
`define CMS_CTL_DISABLE 2
`define CMS_CTL_CGA_LSB 3
`define CMS_CTL_CGA_MSB 4
`define CMS_CTL_OFFHOOK 5
`define CMS_CTL_RING 6
// Card control fields
`define CMS_CARD_MODE_LSB 0
`define CMS_CARD_MODE_MSB 1
`define CMS_CARD_BADSW 2
`define CMS_CARD_MAPPED 3
`define CMS_CARD_ALARM 4
// Reset values
`define CMS_CTL_RESET 32'h00000018
`define CMS_CARD_RESET 32'h00000000
// Gain: 0.1 dB steps, -17.4 dBm (code 0) to +8.0 dBm (code 254)
`define CMS_GAIN_MAX 8'hfe
`define CMS_GAIN_RESET 8'h0e
// Timing
`define CMS_CLK_HZ 40000000
`define CMS_SLOW_HALF_MS 1000
`define CMS_FAST_HZ 5
`define CMS_CGA_DELAY_MS 3000
`endif

/* cms_pkg.sv */
// Types for the channel maintenance and status block
package cms_pkg;
    typedef enum logic [1:0] {CMS_CGA_RSVD, CMS_CGA_IDLE, CMS_CGA_BUSY, CMS_CGA_IDLE_BUSY} cms_cga_t;
    typedef enum logic [1:0] {CMS_MODE_EM, CMS_MODE_GS, CMS_MODE_LS, CMS_MODE_TO} cms_mode_t;
    typedef enum {CMS_ST_IN, CMS_ST_WAIT, CMS_ST_OUT} cms_state_t;
endpackage

/* cms_chan_if.sv */
// Bundle between the card top and one channel slice
`timescale 1ns/1ps
interface cms_chan_if;
    logic loop_req;
    logic defer_req;
    logic disable_req;
    logic [1:0] cga_type;
    logic off_hook;
    logic out_of_service;
    logic waiting;
    logic e_force;
    logic e_force_busy;
    modport top (output loop_req, defer_req, disable_req, cga_type, off_hook,
                 input out_of_service, waiting, e_force, e_force_busy);
    modport chan (input loop_req, defer_req, disable_req, cga_type, off_hook,
                  output out_of_service, waiting, e_force, e_force_busy);
endinterface

/* cms_chan.sv */
// One channel: service state and trunk conditioning
`timescale 1ns/1ps
`include "cms_consts.svh"
module cms_chan #(
    parameter int DELAY_CYC = 120000000
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Channel bundle
    cms_chan_if.chan ch
);
    import cms_pkg::*;
    cms_state_t state;
    logic [31:0] cga_cnt;
    logic force_active;

    initial
    begin
        if (DELAY_CYC < 1)
            $error("DELAY_CYC must be positive");
    end

    // Service state; deferred removal waits for on-hook
    // removal paths
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            state <= CMS_ST_IN;
        else
            case (state)
                CMS_ST_IN:
                    if (ch.disable_req)
                        state <= CMS_ST_OUT;
                    else if (ch.defer_req)
                        state <= ch.off_hook ? CMS_ST_WAIT : CMS_ST_OUT;
                CMS_ST_WAIT:
                    if (ch.disable_req || !ch.off_hook)
                        state <= CMS_ST_OUT;
                    else if (!ch.defer_req)
                        state <= CMS_ST_IN;
                CMS_ST_OUT:
                    if (!ch.disable_req && !ch.defer_req)
                        state <= CMS_ST_IN;
                default:
                    state <= CMS_ST_IN;
            endcase
    end

    assign ch.out_of_service = (state == CMS_ST_OUT);
    assign ch.waiting = (state == CMS_ST_WAIT);
    assign force_active = ch.out_of_service || ch.loop_req;
    assign ch.e_force = force_active;

    // Idle-to-busy timer for the third alarm type; loopback shows final state
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            cga_cnt <= 32'h0;
        else if (!ch.out_of_service)
            cga_cnt <= 32'h0;
        else if (cga_cnt < DELAY_CYC)
            cga_cnt <= cga_cnt + 32'h1;
    end

    always_comb
    begin
        case (ch.cga_type)
            CMS_CGA_IDLE: ch.e_force_busy = 1'b0;
            CMS_CGA_BUSY: ch.e_force_busy = 1'b1;
            default: ch.e_force_busy = ch.loop_req || (cga_cnt >= DELAY_CYC);
        endcase
    end

    // Disable takes the channel out in one edge
    property p_disable_now;
        @(posedge clk_sys) disable iff (!nrst)
        ch.disable_req |=> ch.out_of_service;
    endproperty
    a_disable_now: assert property (p_disable_now) else $error("disable not immediate");

    // Deferred request never drops a busy call
    property p_defer_keeps_call;
        @(posedge clk_sys) disable iff (!nrst)
        (state == CMS_ST_IN && ch.defer_req && !ch.disable_req && ch.off_hook) |=> ch.waiting;
    endproperty
    a_defer_keeps_call: assert property (p_defer_keeps_call) else $error("call dropped");

    // Type one is idle, type two busy
    property p_cga_types;
        @(posedge clk_sys) disable iff (!nrst)
        ch.e_force |-> ((ch.cga_type != CMS_CGA_IDLE) || !ch.e_force_busy)
                      && ((ch.cga_type != CMS_CGA_BUSY) || ch.e_force_busy);
    endproperty
    a_cga_types: assert property (p_cga_types) else $error("alarm type wrong");
endmodule

/* cms_top.sv */
// Dual channel maintenance and status logic with APB registers
//
// Behaviour
// - Loop network PCM back per channel on command
// - Loopback drives E-lead to final alarm state
// - Customer voice path is never looped back
// - Deferred removal waits until channel idle
// - Unconditional disable removes channel at once
// - Out of service forces signalling per alarm
// - Out of service blinks one second cadence
// - Idle channel indicator stays dark
// - Busy channel indicator stays lit
// - Ringing channel indicator follows ringing cadence
// - Bad switches blink five times per second
// - Transmission-only blinks on alarm or unmapped
// - Transmission-only mapped and clear stays lit
// - Transmit gain in 0.1 dB steps
// - Transmission-only robs no PCM bits
// - Ground-start tandem: voice channel one only
// - Loop-start tandem: two independent circuits
// - Alarm types idle, busy, idle-then-busy; default three
//
// Implementation choices: the APB slave port and the address map.
`timescale 1ns/1ps
`include "cms_consts.svh"
module cms_top #(
    parameter int CLK_HZ = `CMS_CLK_HZ,
    parameter int CGA_DELAY_CYC = (`CMS_CGA_DELAY_MS / 1000) * `CMS_CLK_HZ
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Network PCM per channel (A, B)
    input wire logic [7:0] pcm_net_in_a,
    input wire logic [7:0] pcm_net_in_b,
    output logic [7:0] pcm_net_out_a,
    output logic [7:0] pcm_net_out_b,
    // Customer side encoded voice per channel
    input wire logic [7:0] pcm_cust_in_a,
    input wire logic [7:0] pcm_cust_in_b,
    output logic [7:0] pcm_cust_out_a,
    output logic [7:0] pcm_cust_out_b,
    // Trunk signalling
    input wire logic [1:0] sig_net_in_a,
    input wire logic [1:0] sig_net_in_b,
    input wire logic m_lead_a,
    input wire logic m_lead_b,
    output logic e_lead_a,
    output logic e_lead_b,
    output logic [1:0] sig_net_out_a,
    output logic [1:0] sig_net_out_b,
    output logic rob_bits_en,
    // Gains and indicators
    output logic [7:0] tx_gain_a,
    output logic [7:0] tx_gain_b,
    output logic led_a,
    output logic led_b
);
    import cms_pkg::*;
    localparam int SLOW_HALF = int'(longint'(CLK_HZ) * `CMS_SLOW_HALF_MS / 1000);
    localparam int FAST_HALF = CLK_HZ / (2 * `CMS_FAST_HZ);

    initial
    begin
        if (CLK_HZ < 2 * `CMS_FAST_HZ || CGA_DELAY_CYC < 1 || SLOW_HALF < 1)
            $error("clock rate or alarm delay out of range");
    end

    logic [31:0] ctrl [2];
    logic [31:0] card;
    logic [7:0] gain [2];
    logic [31:0] tb_slow;
    logic [31:0] tb_fast;
    logic blink_slow;
    logic blink_fast;
    logic [1:0] oos;
    logic [1:0] wait_st;
    logic [1:0] ef;
    logic [1:0] efb;
    logic [1:0] led;
    logic [1:0] e_out;
    logic [1:0] sig_out [2];
    logic [7:0] net_out [2];
    logic [7:0] cust_out [2];
    logic [7:0] net_in [2];
    logic [7:0] cust_in [2];
    logic [1:0] sig_in [2];
    logic [1:0] m_in;
    cms_mode_t mode;
    logic wr_en;
    logic rd_en;
    logic addr_ok;

    assign mode = cms_mode_t'(card[`CMS_CARD_MODE_MSB:`CMS_CARD_MODE_LSB]);
    assign net_in[0] = pcm_net_in_a;
    assign net_in[1] = pcm_net_in_b;
    assign cust_in[0] = pcm_cust_in_a;
    assign cust_in[1] = pcm_cust_in_b;
    assign sig_in[0] = sig_net_in_a;
    assign sig_in[1] = sig_net_in_b;
    assign m_in = {m_lead_b, m_lead_a};

    // APB decode; zero wait states
    assign pready = 1'b1;
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;
    always_comb
    begin
        case (paddr)
            `CMS_OFF_CTRL_A, `CMS_OFF_CTRL_B, `CMS_OFF_CARD,
            `CMS_OFF_STAT, `CMS_OFF_GAIN_A, `CMS_OFF_GAIN_B: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end
    assign pslverr = psel && penable && !addr_ok;

    // Register writes
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            ctrl[0] <= `CMS_CTL_RESET;
            ctrl[1] <= `CMS_CTL_RESET;
            card <= `CMS_CARD_RESET;
        end
        else if (wr_en)
        begin
            if (paddr == `CMS_OFF_CTRL_A)
                ctrl[0] <= {25'h0, pwdata[6:0]};
            if (paddr == `CMS_OFF_CTRL_B)
                ctrl[1] <= {25'h0, pwdata[6:0]};
            if (paddr == `CMS_OFF_CARD)
                card <= {27'h0, pwdata[4:0]};
        end
    end

    // Gain provisioning, clamped to +8.0 dBm top code
    // gain step codes
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            gain[0] <= `CMS_GAIN_RESET;
            gain[1] <= `CMS_GAIN_RESET;
        end
        else if (wr_en)
        begin
            if (paddr == `CMS_OFF_GAIN_A)
                gain[0] <= (pwdata[7:0] > `CMS_GAIN_MAX) ? `CMS_GAIN_MAX : pwdata[7:0];
            if (paddr == `CMS_OFF_GAIN_B)
                gain[1] <= (pwdata[7:0] > `CMS_GAIN_MAX) ? `CMS_GAIN_MAX : pwdata[7:0];
        end
    end
    assign tx_gain_a = gain[0];
    assign tx_gain_b = gain[1];

    // Read data registered in setup phase
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            prdata <= 32'h0;
        else if (psel && !penable && !pwrite)
            case (paddr)
                `CMS_OFF_CTRL_A: prdata <= ctrl[0];
                `CMS_OFF_CTRL_B: prdata <= ctrl[1];
                `CMS_OFF_CARD: prdata <= card;
                `CMS_OFF_STAT: prdata <= {24'h0, led, wait_st, oos, m_in};
                `CMS_OFF_GAIN_A: prdata <= {24'h0, gain[0]};
                `CMS_OFF_GAIN_B: prdata <= {24'h0, gain[1]};
                default: prdata <= 32'h0;
            endcase
    end

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            tb_slow <= 32'h0;
            blink_slow <= 1'b0;
        end
        else if (tb_slow >= 32'(SLOW_HALF - 1))
        begin
            tb_slow <= 32'h0;
            blink_slow <= !blink_slow;
        end
        else
            tb_slow <= tb_slow + 32'h1;
    end

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            tb_fast <= 32'h0;
            blink_fast <= 1'b0;
        end
        else if (tb_fast >= 32'(FAST_HALF - 1))
        begin
            tb_fast <= 32'h0;
            blink_fast <= !blink_fast;
        end
        else
            tb_fast <= tb_fast + 32'h1;
    end

    // Channel slices
    for (genvar i = 0; i < 2; i++)
    begin : g_ch
        cms_chan_if cif ();
        assign cif.loop_req = ctrl[i][`CMS_CTL_LOOP];
        assign cif.defer_req = ctrl[i][`CMS_CTL_DEFER];
        assign cif.disable_req = ctrl[i][`CMS_CTL_DISABLE];
        assign cif.cga_type = ctrl[i][`CMS_CTL_CGA_MSB:`CMS_CTL_CGA_LSB];
        assign cif.off_hook = ctrl[i][`CMS_CTL_OFFHOOK] | m_in[i];
        assign oos[i] = cif.out_of_service;
        assign wait_st[i] = cif.waiting;
        assign ef[i] = cif.e_force;
        assign efb[i] = cif.e_force_busy;
        cms_chan #(.DELAY_CYC(CGA_DELAY_CYC)) u_chan (
            .clk_sys(clk_sys),
            .nrst(nrst),
            .ch(cif)
        );

        // Datapath; loopback returns network data, customer leg muted
        always_ff @(posedge clk_sys or negedge nrst)
        begin
            if (!nrst)
            begin
                net_out[i] <= 8'h0;
                cust_out[i] <= 8'hff;
            end
            else
            begin
                if (ctrl[i][`CMS_CTL_LOOP])
                    net_out[i] <= net_in[i];
                // ground start voice only on channel one
                else if (mode == CMS_MODE_GS && i == 1)
                    net_out[i] <= 8'hff;
                else
                    net_out[i] <= cust_in[i];
                if (ctrl[i][`CMS_CTL_LOOP] || (mode == CMS_MODE_GS && i == 1))
                    cust_out[i] <= 8'hff;
                else
                    cust_out[i] <= net_in[i];
            end
        end

        // Trunk signalling; forced state overrides the live leads
        always_ff @(posedge clk_sys or negedge nrst)
        begin
            if (!nrst)
            begin
                e_out[i] <= 1'b0;
                sig_out[i] <= 2'b00;
            end
            else if (ef[i])
            begin
                e_out[i] <= efb[i];
                sig_out[i] <= {2{efb[i]}};
            end
            // both lead sets carry ground-start states
            else if (mode == CMS_MODE_GS)
            begin
                e_out[i] <= sig_in[0][i];
                sig_out[i] <= {m_in[1], m_in[0]};
            end
            else
            begin
                e_out[i] <= sig_in[i][0];
                sig_out[i] <= {2{m_in[i]}};
            end
        end

        always_comb
        begin
            if (mode == CMS_MODE_TO)
                led[i] = (card[`CMS_CARD_ALARM] || !card[`CMS_CARD_MAPPED]) ? blink_slow : 1'b1;
            else if (card[`CMS_CARD_BADSW])
                led[i] = blink_fast;
            else if (oos[i])
                led[i] = blink_slow;
            else if (ctrl[i][`CMS_CTL_RING])
                led[i] = sig_in[i][1];
            else
                led[i] = cif.off_hook;
        end
    end

    assign pcm_net_out_a = net_out[0];
    assign pcm_net_out_b = net_out[1];
    assign pcm_cust_out_a = cust_out[0];
    assign pcm_cust_out_b = cust_out[1];
    assign e_lead_a = e_out[0];
    assign e_lead_b = e_out[1];
    assign sig_net_out_a = sig_out[0];
    assign sig_net_out_b = sig_out[1];
    assign rob_bits_en = (mode != CMS_MODE_TO);
    assign led_a = led[0];
    assign led_b = led[1];

    // Loopback returns network data next edge
    property p_loop;
        @(posedge clk_sys) disable iff (!nrst)
        ctrl[0][`CMS_CTL_LOOP] |=> (pcm_net_out_a == $past(pcm_net_in_a));
    endproperty
    a_loop: assert property (p_loop) else $error("loopback data wrong");

    property p_loop_e;
        @(posedge clk_sys) disable iff (!nrst)
        (ctrl[0][`CMS_CTL_LOOP] && ctrl[0][4:3] == 2'd2) |=> e_lead_a;
    endproperty
    a_loop_e: assert property (p_loop_e) else $error("loop E-lead wrong");

    property p_no_cust_loop;
        @(posedge clk_sys) disable iff (!nrst)
        ctrl[0][`CMS_CTL_LOOP] |=> (pcm_cust_out_a == 8'hff);
    endproperty
    a_no_cust_loop: assert property (p_no_cust_loop) else $error("customer looped");

    property p_force;
        @(posedge clk_sys) disable iff (!nrst)
        (oos[0] && efb[0]) |=> (sig_net_out_a == 2'b11);
    endproperty
    a_force: assert property (p_force) else $error("forced signalling wrong");

    property p_badsw;
        @(posedge clk_sys) disable iff (!nrst)
        (mode != CMS_MODE_TO && card[`CMS_CARD_BADSW]) |-> (led_a == blink_fast);
    endproperty
    a_badsw: assert property (p_badsw) else $error("bad switch led");

    property p_to_lit;
        @(posedge clk_sys) disable iff (!nrst)
        (mode == CMS_MODE_TO && card[`CMS_CARD_MAPPED] && !card[`CMS_CARD_ALARM]) |-> led_a;
    endproperty
    a_to_lit: assert property (p_to_lit) else $error("mapped led not lit");

    property p_rob;
        @(posedge clk_sys) disable iff (!nrst)
        (mode == CMS_MODE_TO) |-> !rob_bits_en;
    endproperty
    a_rob: assert property (p_rob) else $error("bits robbed");

    property p_idle_dark;
        @(posedge clk_sys) disable iff (!nrst)
        (mode != CMS_MODE_TO && !card[`CMS_CARD_BADSW] && !oos[0]
         && !ctrl[0][`CMS_CTL_RING] && !ctrl[0][`CMS_CTL_OFFHOOK] && !m_lead_a) |-> !led_a;
    endproperty
    a_idle_dark: assert property (p_idle_dark) else $error("idle led lit");

    c_loop: cover property (@(posedge clk_sys) disable iff (!nrst) ctrl[0][`CMS_CTL_LOOP]);
    c_wait: cover property (@(posedge clk_sys) disable iff (!nrst) wait_st[0] ##1 oos[0]);
    c_oos_blink: cover property (@(posedge clk_sys) disable iff (!nrst) oos[1] && led_b);
endmodule

/* cms_backplane.sv */
// Backplane model: network PCM and signalling toward the card
`timescale 1ns/1ps
module cms_backplane (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Signalling control from the bench
    input wire logic ring_bit,
    input wire logic a_bit,
    // Network side toward the card
    output logic [7:0] pcm_net_in_a,
    output logic [7:0] pcm_net_in_b,
    output logic [1:0] sig_net_in_a,
    output logic [1:0] sig_net_in_b
);
    // Fresh byte every slot, so a stale or stuck path never matches
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            pcm_net_in_a <= 8'h00;
            pcm_net_in_b <= 8'h80;
        end
        else
        begin
            pcm_net_in_a <= pcm_net_in_a + 8'h01;
            pcm_net_in_b <= pcm_net_in_b - 8'h03;
        end
    end
    // Bit 1 ringing cadence, bit 0 far end hook; B mirrors A inverted
    assign sig_net_in_a = {ring_bit, a_bit};
    assign sig_net_in_b = {~ring_bit, ~a_bit};
endmodule

/* channel_maintenance_status_bench.sv */
// Self-checking bench for the channel maintenance and status block
`timescale 1ns/1ps
`include "cms_consts.svh"
module channel_maintenance_status_bench;
    typedef struct {
        logic [11:0] addr;
        logic [31:0] wdata;
        logic [31:0] exp;
        logic err;
    } cms_row_t;
    // Short blink and alarm counts keep the run brief
    localparam int HZ = 100;
    localparam int DLY = 20;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, rob_bits_en, e_lead_a, e_lead_b, led_a, led_b;
    logic [7:0] pcm_net_in_a, pcm_net_in_b, pcm_net_out_a, pcm_net_out_b;
    logic [7:0] pcm_cust_out_a, pcm_cust_out_b, tx_gain_a, tx_gain_b, prev_a, prev_b;
    logic [7:0] pcm_cust_in_a = 8'h3c;
    logic [7:0] pcm_cust_in_b = 8'hc3;
    logic [1:0] sig_net_in_a, sig_net_in_b, sig_net_out_a, sig_net_out_b;
    logic m_lead_a = 1'b0;
    logic m_lead_b = 1'b0;
    logic ring_bit = 1'b0;
    logic a_bit = 1'b0;
    int n_errors = 0;
    int checks_done = 0;
    cms_row_t rows [6];

    // 40 MHz system clock
    always #12.5 clk_sys = ~clk_sys;
    // Network bytes one slot old, as the registered paths should show them
    always @(posedge clk_sys)
    begin
        prev_a <= pcm_net_in_a;
        prev_b <= pcm_net_in_b;
    end

    cms_backplane net (.clk_sys, .nrst, .ring_bit, .a_bit, .pcm_net_in_a, .pcm_net_in_b,
        .sig_net_in_a, .sig_net_in_b);
    cms_top #(.CLK_HZ(HZ), .CGA_DELAY_CYC(DLY)) dut (.clk_sys, .nrst, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .pcm_net_in_a, .pcm_net_in_b,
        .pcm_net_out_a, .pcm_net_out_b, .pcm_cust_in_a, .pcm_cust_in_b, .pcm_cust_out_a,
        .pcm_cust_out_b, .sig_net_in_a, .sig_net_in_b, .m_lead_a, .m_lead_b, .e_lead_a,
        .e_lead_b, .sig_net_out_a, .sig_net_out_b, .rob_bits_en, .tx_gain_a, .tx_gain_b,
        .led_a, .led_b);

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic hang(input string what);
        n_errors++;
        $display("CHECK FAILED %s expected event seen none", what);
        conclude();
    endtask
    // One APB transfer; request held until pready is seen high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic er);
        int i;
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        for (i = 0; i < 20; i++)
        begin
            @(posedge clk_sys);
            if (pready === 1'b1)
                break;
        end
        if (i == 20)
            hang("pready");
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic er;
        apb(1'b1, a, d, rd, er);
    endtask
    task automatic rdm(input string what, input logic [11:0] a, input logic [31:0] m,
                       input logic [31:0] exp);
        logic [31:0] rd;
        logic er;
        apb(1'b0, a, 32'h0, rd, er);
        chk(what, rd & m, exp);
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask
    // Cycles between two indicator edges; hangs out if it never moves
    task automatic half(output int n);
        logic v;
        int i;
        @(negedge clk_sys);
        v = led_a;
        for (i = 0; i < 300 && led_a === v; i++)
            @(negedge clk_sys);
        if (i == 300)
            hang("led toggle");
        v = led_a;
        n = 0;
        while (n < 300 && led_a === v)
        begin
            @(negedge clk_sys);
            n++;
        end
    endtask

    initial
    begin
        logic [31:0] rd;
        logic er;
        int n;
        int t;
        rows = '{'{`CMS_OFF_GAIN_A, 32'h0, 32'h0, 1'b0}, '{`CMS_OFF_GAIN_A, 32'hff, 32'hfe, 1'b0},
            '{`CMS_OFF_GAIN_B, 32'h50, 32'h50, 1'b0}, '{`CMS_OFF_CARD, 32'h1f, 32'h1f, 1'b0},
            '{`CMS_OFF_CTRL_B, 32'h7f, 32'h7f, 1'b0}, '{12'h020, 32'ha5, 32'h0, 1'b1}};
        repeat (6) @(posedge clk_sys);
        nrst <= 1'b1;
        rdm("ctrl reset", `CMS_OFF_CTRL_A, 32'hffffffff, `CMS_CTL_RESET);
        rdm("gain reset", `CMS_OFF_GAIN_A, 32'hff, `CMS_GAIN_RESET);
        chk("rob reset", rob_bits_en, 1'b1);
        // Register rows: write, read back, compare data and error
        foreach (rows[i])
        begin
            apb(1'b1, rows[i].addr, rows[i].wdata, rd, er);
            apb(1'b0, rows[i].addr, 32'h0, rd, er);
            chk("row data", rd, rows[i].exp);
            chk("row err", er, rows[i].err);
        end
        settle(1);
        chk("tx gain a", tx_gain_a, `CMS_GAIN_MAX);
        chk("tx gain b", tx_gain_b, 32'h50);
        wr(`CMS_OFF_CARD, 32'h0);
        wr(`CMS_OFF_CTRL_B, `CMS_CTL_RESET);
        // Loopback under each alarm type, channel B untouched
        for (t = 1; t <= 3; t++)
        begin
            wr(`CMS_OFF_CTRL_A, (t << `CMS_CTL_CGA_LSB) | 32'h1);
            settle(2);
            chk("loop e lead", e_lead_a, t != 1);
            chk("loop net out", pcm_net_out_a, prev_a);
            chk("loop cust out", pcm_cust_out_a, 8'hff);
            chk("b net out", pcm_net_out_b, pcm_cust_in_b);
        end
        wr(`CMS_OFF_CTRL_A, `CMS_CTL_RESET);
        a_bit <= 1'b1;
        settle(2);
        chk("e lead follows", e_lead_a, 1'b1);
        chk("cust out", pcm_cust_out_a, prev_a);
        chk("net out", pcm_net_out_a, pcm_cust_in_a);
        a_bit <= 1'b0;
        // Forced removal during a call, each alarm type
        m_lead_a <= 1'b1;
        for (t = 1; t <= 3; t++)
        begin
            wr(`CMS_OFF_CTRL_A, `CMS_CTL_RESET);
            settle(2);
            wr(`CMS_OFF_CTRL_A, (t << `CMS_CTL_CGA_LSB) | 32'h4);
            settle(3);
            chk("oos early e", e_lead_a, t == 2);
            settle(DLY + 5);
            chk("oos late e", e_lead_a, t != 1);
            chk("oos late sig", sig_net_out_a, (t != 1) ? 2'b11 : 2'b00);
            rdm("oos flag", `CMS_OFF_STAT, 32'h4, 32'h4);
        end
        half(n);
        chk("oos blink", n, HZ);
        wr(`CMS_OFF_CARD, 32'h4);
        half(n);
        chk("bad switch blink", n, HZ / 10);
        wr(`CMS_OFF_CARD, 32'h0);
        // Deferred removal waits for on-hook
        wr(`CMS_OFF_CTRL_A, `CMS_CTL_RESET);
        settle(2);
        wr(`CMS_OFF_CTRL_A, 32'h1a);
        settle(3);
        rdm("waiting", `CMS_OFF_STAT, 32'h14, 32'h10);
        m_lead_a <= 1'b0;
        settle(3);
        rdm("out once idle", `CMS_OFF_STAT, 32'h14, 32'h04);
        // In service indicator: busy, idle, ringing
        wr(`CMS_OFF_CTRL_A, `CMS_CTL_RESET);
        m_lead_a <= 1'b1;
        settle(2);
        chk("led busy", led_a, 1'b1);
        m_lead_a <= 1'b0;
        settle(2);
        chk("led idle", led_a, 1'b0);
        wr(`CMS_OFF_CTRL_A, 32'h58);
        ring_bit <= 1'b1;
        settle(2);
        chk("led ring on", led_a, 1'b1);
        ring_bit <= 1'b0;
        settle(2);
        chk("led ring off", led_a, 1'b0);
        // Transmission-only card
        wr(`CMS_OFF_CARD, 32'h0b);
        settle(2);
        chk("to mapped led", led_a, 1'b1);
        chk("to no robbing", rob_bits_en, 1'b0);
        for (t = 0; t < 2; t++)
        begin
            wr(`CMS_OFF_CARD, t == 0 ? 32'h1b : 32'h03);
            half(n);
            chk("to blink", n < 300, 1'b1);
        end
        // Tandem modes
        wr(`CMS_OFF_CARD, 32'h01);
        settle(2);
        chk("gs b muted", pcm_cust_out_b, 8'hff);
        chk("gs a voice", pcm_cust_out_a, prev_a);
        wr(`CMS_OFF_CARD, 32'h02);
        settle(2);
        chk("ls b voice", pcm_cust_out_b, prev_b);
        chk("ls b e lead", e_lead_b, 1'b1);
        chk("ls a e lead", e_lead_a, 1'b0);
        chk("ls b sig", sig_net_out_b, 2'b00);
        chk("ls b led idle", led_b, 1'b0);
        // Reset in mid-run restores defaults
        nrst <= 1'b0;
        settle(2);
        chk("gain after reset", tx_gain_a, `CMS_GAIN_RESET);
        @(posedge clk_sys);
        nrst <= 1'b1;
        rdm("ctrl after reset", `CMS_OFF_CTRL_A, 32'hffffffff, `CMS_CTL_RESET);
        conclude();
    end
endmodule
